// File: inc/uper_pkg.sv
package uper_pkg;

	localparam int UPER_AW = 8;
	localparam int UPER_NIND = 5;

	// printed offsets are register indices; byte address = 4 * index
	localparam logic [5:0] UPER_RISE_BASE = 6'h0D;
	localparam logic [5:0] UPER_RISE_SET = 6'h0E;
	localparam logic [5:0] UPER_RISE_CLR = 6'h0F;
	localparam logic [5:0] UPER_FALL_BASE = 6'h10;
	localparam logic [5:0] UPER_FALL_SET = 6'h11;
	localparam logic [5:0] UPER_FALL_CLR = 6'h12;
	localparam logic [5:0] UPER_STATUS = 6'h13;
	localparam logic [5:0] UPER_LATCH = 6'h14;
	localparam logic [5:0] UPER_DEBUG = 6'h15;
	localparam logic [5:0] UPER_SCR_BASE = 6'h16;
	localparam logic [5:0] UPER_SCR_SET = 6'h17;
	localparam logic [5:0] UPER_SCR_CLR = 6'h18;
	localparam logic [5:0] UPER_IRQ_MASK = 6'h20;
	localparam logic [5:0] UPER_MODE = 6'h21;

	localparam int UPER_BIT_DETACH = 0;
	localparam int UPER_BIT_VBUS = 1;
	localparam int UPER_BIT_SVALID = 2;
	localparam int UPER_BIT_SEND = 3;
	localparam int UPER_BIT_ID_PIN_GROUNDED = 4;
	localparam int UPER_BIT_HOST = 0;

	localparam logic [4:0] UPER_EN_RESET = 5'h1F;
	localparam logic [7:0] UPER_SCR_RESET = 8'h00;
	localparam logic [4:0] UPER_MASK_RESET = 5'h00;
	localparam logic [31:0] UPER_UNMAPPED = 32'h00000000;

	typedef struct packed {
		logic id_pin_grounded;
		logic session_power_low;
		logic session_power_ok;
		logic vbus_good;
		logic detach;
	} uper_ind_s;

	typedef struct packed {
		logic read;
		logic write;
		logic [UPER_AW-1:0] address;
		logic [31:0] writedata;
	} uper_req_s;

endpackage : uper_pkg

// File: logic/uper_event_regs.sv
// Functional notes
// - rise enable: write/set/clear, resets ones
// - detach rising event only in host mode
// - bus power good rising event
// - session ok, low, id rising events
// - fall enable: write/set/clear, resets ones
// - falling events; detach only in host
// - status shows live indicators, no latch
// - power good status zero if both enabled
// - session low status zero if both
// - session ok status always live
// - status zero only right after reset
// - latch bit set on enabled edge
// - latch clears on read, not writable
// - debug shows two-bit line level
// - scratch byte write/set/clear, no effect
//
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module uper_event_regs
	import uper_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [UPER_AW-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic host_disconnect,
	input wire logic vbus_good,
	input wire logic session_power_ok,
	input wire logic session_power_low,
	input wire logic id_pin_grounded,
	input wire logic [1:0] line_state,
	output logic irq
);

	typedef enum logic [1:0] {UPER_IDLE, UPER_ACK} uper_bus_e;

	function automatic logic [7:0] reg_update(input logic [7:0] cur, input logic [7:0] d,
			input logic [1:0] kind);
		case (kind)
			2'h0: reg_update = d;
			2'h1: reg_update = cur | d;
			2'h2: reg_update = cur & ~d;
			default: reg_update = cur;
		endcase
	endfunction : reg_update

	uper_bus_e bus_state;
	uper_ind_s sync1;
	uper_ind_s sync2;
	uper_ind_s sync3;
	uper_ind_s ind;
	logic [1:0] ls1;
	logic [1:0] ls2;
	logic [1:0] ls3;
	logic [1:0] ls;
	logic [4:0] rise_en;
	logic [4:0] fall_en;
	logic [4:0] latch;
	logic [4:0] irq_mask;
	logic [7:0] scratch;
	logic host_mode;

	uper_req_s req;
	assign req = '{read: avs_read, write: avs_write, address: avs_address,
		writedata: avs_writedata};

	wire [5:0] idx = req.address[7:2];
	wire take = (bus_state == UPER_IDLE) && (req.read || req.write);
	wire wr = take && req.write;
	wire rd = take && req.read;
	wire [7:0] wd = req.writedata[7:0];

	wire wr_rise = wr && (idx >= UPER_RISE_BASE) && (idx <= UPER_RISE_CLR);
	wire [1:0] rise_kind = 2'(idx - UPER_RISE_BASE);
	wire wr_fall = wr && (idx >= UPER_FALL_BASE) && (idx <= UPER_FALL_CLR);
	wire [1:0] fall_kind = 2'(idx - UPER_FALL_BASE);
	wire wr_scr = wr && (idx >= UPER_SCR_BASE) && (idx <= UPER_SCR_CLR);
	wire [1:0] scr_kind = 2'(idx - UPER_SCR_BASE);

	// pin inputs: a change counts once stages two and three agree
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sync1 <= '0;
			sync2 <= '0;
			sync3 <= '0;
			ls1 <= 2'h0;
			ls2 <= 2'h0;
			ls3 <= 2'h0;
		end else begin
			sync1 <= {id_pin_grounded, session_power_low, session_power_ok, vbus_good,
				host_disconnect};
			sync2 <= sync1;
			sync3 <= sync2;
			ls1 <= line_state;
			ls2 <= ls1;
			ls3 <= ls2;
		end
	end

	wire [4:0] agree = ~(sync2 ^ sync3);
	wire [4:0] ls_agree = {3'h0, ~(ls2 ^ ls3)};
	wire [4:0] ind_bits = ind;
	wire [4:0] next_ind_bits = (sync2 & agree) | (ind_bits & ~agree);

	wire [4:0] edge_ok = {4'hF, host_mode};
	wire [4:0] rise_ev = next_ind_bits & ~ind_bits & rise_en & edge_ok;
	wire [4:0] fall_ev = ~next_ind_bits & ind_bits & fall_en & edge_ok;
	wire [4:0] events = rise_ev | fall_ev;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ind <= '0;
			ls <= 2'h0;
		end else begin
			ind <= next_ind_bits;
			ls <= (ls2 & ls_agree[1:0]) | (ls & ~ls_agree[1:0]);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rise_en <= UPER_EN_RESET;
		end else if (wr_rise) begin
			rise_en <= 5'(reg_update({3'h0, rise_en}, wd, rise_kind));
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			fall_en <= UPER_EN_RESET;
		end else if (wr_fall) begin
			fall_en <= 5'(reg_update({3'h0, fall_en}, wd, fall_kind));
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			scratch <= UPER_SCR_RESET;
		end else if (wr_scr) begin
			scratch <= reg_update(scratch, wd, scr_kind);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			irq_mask <= UPER_MASK_RESET;
			host_mode <= 1'b0;
		end else if (wr && idx == UPER_IRQ_MASK) begin
			irq_mask <= wd[4:0];
		end else if (wr && idx == UPER_MODE) begin
			host_mode <= wd[UPER_BIT_HOST];
		end
	end

	wire rd_latch = rd && (idx == UPER_LATCH);
	wire [4:0] next_latch = (rd_latch ? 5'h00 : latch) | events;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			latch <= '0;
		end else begin
			latch <= next_latch;
		end
	end

	// zero only until inputs settle after reset
	// power good hidden when both enabled
	// session low hidden when both enabled
	wire [4:0] status_view = {ind.id_pin_grounded,
		ind.session_power_low & ~(rise_en[UPER_BIT_SEND] & fall_en[UPER_BIT_SEND]),
		ind.session_power_ok,
		ind.vbus_good & ~(rise_en[UPER_BIT_VBUS] & fall_en[UPER_BIT_VBUS]),
		ind.detach};

	logic [31:0] rd_mux;
	always_comb begin
		case (idx)
			UPER_RISE_BASE, UPER_RISE_SET, UPER_RISE_CLR: rd_mux = {27'h0, rise_en};
			UPER_FALL_BASE, UPER_FALL_SET, UPER_FALL_CLR: rd_mux = {27'h0, fall_en};
			UPER_STATUS: rd_mux = {27'h0, status_view};
			UPER_LATCH: rd_mux = {27'h0, latch};
			// line level in low two bits
			UPER_DEBUG: rd_mux = {30'h0, ls};
			UPER_SCR_BASE, UPER_SCR_SET, UPER_SCR_CLR: rd_mux = {24'h0, scratch};
			UPER_IRQ_MASK: rd_mux = {27'h0, irq_mask};
			UPER_MODE: rd_mux = {31'h0, host_mode};
			default: rd_mux = UPER_UNMAPPED;
		endcase
	end

	// one wait state: request taken in idle, answered next cycle
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			bus_state <= UPER_IDLE;
			avs_waitrequest <= 1'b1;
			avs_readdata <= '0;
		end else begin
			case (bus_state)
				UPER_IDLE: begin
					if (take) begin
						bus_state <= UPER_ACK;
						avs_waitrequest <= 1'b0;
						avs_readdata <= rd_mux;
					end
				end
				UPER_ACK: begin
					bus_state <= UPER_IDLE;
					avs_waitrequest <= 1'b1;
				end
				default: begin
					bus_state <= UPER_IDLE;
					avs_waitrequest <= 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(next_latch & irq_mask);
		end
	end

endmodule : uper_event_regs
`default_nettype wire

// File: testbench/uper_event_regs_sva.sv
`timescale 1ns/1ps
`default_nettype none
module uper_chk
	import uper_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [UPER_AW-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic session_power_ok,
	input wire logic id_pin_grounded,
	input wire logic [1:0] line_state,
	input wire logic irq
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	sequence rd_s(idx);
		!avs_waitrequest && avs_read && avs_address[7:2] == idx;
	endsequence
	sequence calm_s(sig);
		($stable(sig) && !rst)[*8];
	endsequence
	reset_state_a: assert property (disable iff (1'b0) rst |=>
		avs_waitrequest && !irq && avs_readdata == 32'h0) else $error("reset state wrong");
	answer_bound_a: assert property ((avs_read || avs_write) && avs_waitrequest |->
		##[0:2] !avs_waitrequest) else $error("no answer");
	ack_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("answer too long");
	upper_zero_a: assert property (!avs_waitrequest && avs_read |->
		avs_readdata[31:8] == 24'h0) else $error("upper bits set");
	reserved_zero_a: assert property (!avs_waitrequest && avs_read
		&& avs_address[7:2] inside {[6'h0D:6'h14]} |-> avs_readdata[7:5] == 3'h0)
		else $error("reserved bits set");
	debug_live_a: assert property (calm_s(line_state) ##0 rd_s(UPER_DEBUG) |->
		avs_readdata[7:0] == {6'h0, line_state}) else $error("debug wrong");
	sess_live_a: assert property (calm_s(session_power_ok) ##0 rd_s(UPER_STATUS) |->
		avs_readdata[2] == session_power_ok) else $error("session bit wrong");
	id_live_a: assert property (calm_s(id_pin_grounded) ##0 rd_s(UPER_STATUS) |->
		avs_readdata[4] == id_pin_grounded) else $error("id bit wrong");
endmodule : uper_chk
bind uper_event_regs uper_chk uper_chk_i (.clk_sys(clk_sys), .rst(rst),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.session_power_ok(session_power_ok), .id_pin_grounded(id_pin_grounded),
	.line_state(line_state), .irq(irq));
`default_nettype wire

// File: testbench/uper_event_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module uper_event_regs_tb;
	import uper_pkg::*;
	logic clk_sys, rst, irq, wq;
	logic [31:0] rdata, q;
	logic [4:0] ind, nx, rise, fall, mask, lat;
	logic [1:0] ls;
	logic [7:0] d, v, m;
	logic [5:0] b;
	uper_req_s req;
	int err_count, n_tests;
	uper_event_regs uper_event_regs_i (.clk_sys(clk_sys), .rst(rst), .avs_address(req.address),
		.avs_read(req.read), .avs_write(req.write), .avs_writedata(req.writedata),
		.avs_readdata(rdata), .avs_waitrequest(wq), .host_disconnect(ind[0]),
		.vbus_good(ind[1]), .session_power_ok(ind[2]), .session_power_low(ind[3]),
		.id_pin_grounded(ind[4]), .line_state(ls), .irq(irq));
	uper_link_model uper_link_model_i (.clk_sys(clk_sys), .req(req), .rdata(rdata),
		.wait_req(wq));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic rd(input logic [5:0] idx, input logic [31:0] exp);
		uper_link_model_i.xfer(1'b0, idx, 8'h00, q);
		chk(q, exp);
	endtask : rd
	task automatic wr(input logic [5:0] idx, input logic [7:0] x);
		uper_link_model_i.xfer(1'b1, idx, x, q);
	endtask : wr
	function automatic logic [31:0] stat(input logic [4:0] i, r, f);
		return {27'h0, i & ~(r & f & 5'h0A)};
	endfunction : stat
	task automatic wrap_up();
		if (err_count == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : wrap_up
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	initial begin
		#200000;
		err_count++;
		wrap_up();
	end
	initial begin
		rst = 1'b1;
		ind = 5'h00;
		ls = 2'h0;
		void'($urandom(32'h0BAE6989));
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		rd(UPER_RISE_CLR, 32'h1F);
		rd(UPER_FALL_SET, 32'h1F);
		rd(UPER_SCR_BASE, 32'h00);
		rd(UPER_STATUS, 32'h00);
		rd(6'h3F, UPER_UNMAPPED);
		for (int k = 0; k < 24; k++) begin
			b = k % 3 == 0 ? UPER_RISE_BASE : k % 3 == 1 ? UPER_FALL_BASE : UPER_SCR_BASE;
			m = k % 3 == 2 ? 8'hFF : 8'h1F;
			v = 8'($urandom);
			wr(b, v);
			d = k < 3 ? 8'hFF : 8'($urandom);
			wr(b + 6'h1, d);
			v |= d;
			d = 8'($urandom);
			wr(b + 6'h2, d);
			v &= ~d;
			rd(b + 6'(k / 3 % 3), {24'h0, v & m});
		end
		for (int k = 0; k < 20; k++) begin
			rise = k == 0 ? 5'h1F : 5'($urandom);
			fall = k == 1 ? 5'h1F : 5'($urandom);
			mask = 5'($urandom);
			wr(UPER_RISE_BASE, {3'h0, rise});
			wr(UPER_FALL_BASE, {3'h0, fall});
			wr(UPER_IRQ_MASK, {3'h0, mask});
			wr(UPER_MODE, 8'(k % 2));
			rd(UPER_IRQ_MASK, {27'h0, mask});
			rd(UPER_MODE, 32'(k % 2));
			nx = k == 0 ? 5'h1F : k == 1 ? 5'h00 : 5'($urandom);
			lat = (nx & ~ind & rise) | (~nx & ind & fall);
			lat[0] = lat[0] & k[0];
			ind <= nx;
			ls <= 2'($urandom);
			repeat (10) @(posedge clk_sys);
			chk({31'h0, irq}, {31'h0, |(lat & mask)});
			rd(UPER_STATUS, stat(nx, rise, fall));
			rd(UPER_DEBUG, {30'h0, ls});
			wr(UPER_LATCH, 8'hFF);
			rd(UPER_LATCH, {27'h0, lat});
			rd(UPER_LATCH, 32'h0);
			chk({31'h0, irq}, 32'h0);
		end
		// event lands on the edge that takes the clearing read
		wr(UPER_RISE_BASE, 8'h1F);
		wr(UPER_FALL_BASE, 8'h1F);
		ind <= ~ind;
		repeat (3) @(posedge clk_sys);
		rd(UPER_LATCH, 32'h0);
		rd(UPER_LATCH, 32'h1F);
		wrap_up();
	end
endmodule : uper_event_regs_tb
`default_nettype wire

// File: testbench/uper_link_model.sv
`timescale 1ns/1ps
`default_nettype none
module uper_link_model
	import uper_pkg::*;
(
	input wire logic clk_sys,
	output uper_req_s req,
	input wire logic [31:0] rdata,
	input wire logic wait_req
);
	initial req = '0;
	task automatic xfer(input logic wr, input logic [5:0] idx, input logic [7:0] d,
		output logic [31:0] q);
		req <= '{read: !wr, write: wr, address: {idx, 2'h0}, writedata: {24'h0, d}};
		do @(posedge clk_sys); while (wait_req !== 1'b0);
		q = rdata;
		req <= '0;
		@(posedge clk_sys);
	endtask : xfer
endmodule : uper_link_model
`default_nettype wire
